//--- lrb_fab.sv
// Purpose: Fabric-side driver of one RAM port
// Assumes: The bench calls one task per port per cycle
// Notes:   Lines change 2 ns after the rising edge
`timescale 1ns/10ps
module lrb_fab
    import lrb_pkg::*;
(
    // Clock
    input  wire logic clk_i,
    // Port controls
    output lrb_req_s  req_o,
    output logic      ce_o,
    output logic      clr_o
);
    initial begin
        req_o = '0;
        ce_o  = 1'b0;
        clr_o = 1'b0;
    end

    // Idle cycles still carry fresh random data lines
    task automatic acc(input lrb_req_s q, input logic ce);
        @(posedge clk_i);
        #2;
        req_o = q;
        ce_o  = ce;
    endtask

    task automatic clr(input logic v);
        @(posedge clk_i);
        #2;
        clr_o = v;
    endtask
endmodule

//--- lrb_map.svh
// Purpose: Constants of the large dual-port RAM block
// Assumes: Included by the package only
// Notes:   Widths, counts and reset values
`ifndef LRB_MAP_SVH
`define LRB_MAP_SVH

`define LRB_TOTAL_BITS 589824
`define LRB_ROWS       4096
`define LRB_ROW_AW     12
`define LRB_ROW_W      144
`define LRB_LANES      16
`define LRB_LANE_W     9
`define LRB_BYTE_W     8
`define LRB_PORT_W     72
`define LRB_PORT_LANES 8
`define LRB_ADDR_W     16
`define LRB_MASK_W     8
`define LRB_RST_DOUT   72'h0
`define LRB_RST_ROW    144'h0
`define LRB_RST_OFS    4'h0

`endif

//--- lrb_mem.sv
// Purpose: Storage array, 4096 rows of sixteen 9-bit lanes
// Assumes: Lane write enables already decoded
// Notes:   Array has no reset; port B wins a same-lane collision
`timescale 1ns/10ps
module lrb_mem
    import lrb_pkg::*;
(
    // Clock and reset
    input  wire logic                    clk_i,
    input  wire logic                    srst_i,
    // Port A
    input  wire logic [`LRB_ROW_AW-1:0]  a_row_i,
    input  wire logic [`LRB_LANES-1:0]   a_we_i,
    input  wire logic [`LRB_ROW_W-1:0]   a_wdata_i,
    input  wire logic                    a_rd_i,
    output logic      [`LRB_ROW_W-1:0]   a_rdata_o,
    // Port B
    input  wire logic [`LRB_ROW_AW-1:0]  b_row_i,
    input  wire logic [`LRB_LANES-1:0]   b_we_i,
    input  wire logic [`LRB_ROW_W-1:0]   b_wdata_i,
    input  wire logic                    b_rd_i,
    output logic      [`LRB_ROW_W-1:0]   b_rdata_o
);
    logic [`LRB_ROW_W-1:0] mem [0:`LRB_ROWS-1];

    // Contents undefined until written
    always_ff @(posedge clk_i) begin
        for (int j = 0; j < `LRB_LANES; j++) begin
            if (a_we_i[j]) begin
                mem[a_row_i][j*`LRB_LANE_W +: `LRB_LANE_W] <=
                    a_wdata_i[j*`LRB_LANE_W +: `LRB_LANE_W];
            end
            if (b_we_i[j]) begin
                mem[b_row_i][j*`LRB_LANE_W +: `LRB_LANE_W] <=
                    b_wdata_i[j*`LRB_LANE_W +: `LRB_LANE_W];
            end
        end
    end

    // Read gives the old row on a same-row write
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            a_rdata_o <= `LRB_RST_ROW;
            b_rdata_o <= `LRB_RST_ROW;
        end else begin
            if (a_rd_i) a_rdata_o <= mem[a_row_i];
            if (b_rd_i) b_rdata_o <= mem[b_row_i];
        end
    end
endmodule

//--- lrb_pkg.sv
// Purpose: Types of the large dual-port RAM block
// Assumes: lrb_map.svh holds the numbers
// Notes:   Geometry code equals log2 of the lanes per word
package lrb_pkg;
`include "lrb_map.svh"

    typedef enum logic [2:0] {
        LRB_W9   = 3'h0,
        LRB_W18  = 3'h1,
        LRB_W36  = 3'h2,
        LRB_W72  = 3'h3,
        LRB_W144 = 3'h4
    } lrb_geom_e;

    typedef enum logic [1:0] {
        LRB_TDP  = 2'h0,
        LRB_SDP  = 2'h1,
        LRB_SP   = 2'h2,
        LRB_FIFO = 2'h3
    } lrb_mode_e;

    typedef struct packed {
        logic                      we;
        logic [`LRB_ADDR_W-1:0]    addr;
        logic [`LRB_PORT_W-1:0]    din;
        logic [`LRB_MASK_W-1:0]    mask;
    } lrb_req_s;
endpackage

//--- lrb_ram.sv
// Purpose: Large dual-port RAM block with mixed widths and lane masks
// Assumes: Both ports driven by logic on clk_i; config held static
// Notes:   Input stage, array read register, optional output stage
`timescale 1ns/10ps

// Summary of operation
// - 589,824-bit array, parity bits included
// - Modes true dual, simple dual, single, FIFO
// - Contents undefined at power-up, no preload
// - Inputs registered; output register can be bypassed
// - Geometries 64Kx9 down to 4Kx144, parity optional
// - 144-bit geometry refused in true dual-port
// - Simple dual pairs freely; 144 only with 144
// - True dual ports take any narrower geometry
// - Write enable picks read or write in true dual and on single port A; simple dual A never reads, B always reads
// - Write lanes gated by mask and write enable
// - Masks for 18, 36 and 72 bit widths
// - Mask bit i gates data bits 9i+8..9i
// - 144-bit mode joins both masks into sixteen
// - Without parity masks gate 8-bit bytes
// - Write, data, address, mask registered together
// - Each port has 72 inputs and 72 outputs
// - Port registers follow their own port's controls
// - Simple dual: write side A, read side B
// - Each port has own enable and clear
module lrb_ram
    import lrb_pkg::*;
(
    // Clock and reset
    input  wire logic                    clk_i,
    input  wire logic                    srst_i,
    // Configuration
    input  wire lrb_mode_e               mode_i,
    input  wire lrb_geom_e               geom_a_i,
    input  wire lrb_geom_e               geom_b_i,
    input  wire logic                    parity_a_i,
    input  wire logic                    parity_b_i,
    input  wire logic                    obypass_a_i,
    input  wire logic                    obypass_b_i,
    output logic                         cfg_err_o,
    // Port A
    input  wire lrb_req_s                req_a_i,
    input  wire logic                    ce_a_i,
    input  wire logic                    oce_a_i,
    input  wire logic                    clr_a_i,
    output logic      [`LRB_PORT_W-1:0]  dout_a_o,
    // Port B
    input  wire lrb_req_s                req_b_i,
    input  wire logic                    ce_b_i,
    input  wire logic                    oce_b_i,
    input  wire logic                    clr_b_i,
    output logic      [`LRB_PORT_W-1:0]  dout_b_o
);
    // Lanes of a word, shifted to its place in the row
    function automatic logic [15:0] lane_sel(input logic [2:0]  k,
                                             input logic [3:0]  a,
                                             input logic [15:0] m);
        logic [15:0] lim;
        logic [3:0]  ofs;
        lim = (16'h1 << (5'h1 << k)) - 16'h1;
        ofs = 4'(a << k);
        lane_sel = ((k == 3'h0) ? 16'h1 : (m & lim)) << ofs;
    endfunction

    function automatic logic [11:0] row_of(input logic [2:0]  k,
                                           input logic [15:0] a);
        row_of = 12'(a >> (3'h4 - k));
    endfunction

    function automatic logic [3:0] ofs_of(input logic [2:0]  k,
                                          input logic [15:0] a);
        ofs_of = 4'(a[3:0] << k);
    endfunction

    // Port data into 9-bit lanes; bytes get a zero ninth bit
    function automatic logic [71:0] widen(input logic [71:0] d,
                                          input logic        par);
        for (int j = 0; j < `LRB_PORT_LANES; j++) begin
            widen[j*9 +: 9] = par ? d[j*9 +: 9] : {1'b0, d[j*8 +: 8]};
        end
    endfunction

    function automatic logic [71:0] narrow(input logic [71:0] l,
                                           input logic        par);
        narrow = `LRB_RST_DOUT;
        for (int j = 0; j < `LRB_PORT_LANES; j++) begin
            if (par) narrow[j*9 +: 9] = l[j*9 +: 9];
            else narrow[j*8 +: 8] = l[j*9 +: 8];
        end
    endfunction

    // Narrow word copied into every slot of the row
    function automatic logic [143:0] place(input logic [143:0] s,
                                           input logic [2:0]   k);
        logic [3:0] msk;
        msk = 4'((5'h1 << k) - 5'h1);
        for (int j = 0; j < `LRB_LANES; j++) begin
            place[j*9 +: 9] = s[(j & msk)*9 +: 9];
        end
    endfunction

    function automatic logic [71:0] pick(input logic [143:0] r,
                                         input logic [3:0]   st,
                                         input logic [2:0]   k);
        logic [3:0] idx;
        pick = `LRB_RST_DOUT;
        for (int j = 0; j < `LRB_PORT_LANES; j++) begin
            idx = 4'(st + 4'(j));
            if (j < (1 << k)) pick[j*9 +: 9] = r[idx*9 +: 9];
        end
    endfunction

    lrb_req_s                req_a_q;
    lrb_req_s                req_b_q;
    logic                    act_a_q;
    logic                    act_b_q;
    logic                    cfg_err_q;
    logic [3:0]              rofs_a_q;
    logic [3:0]              rofs_b_q;
    logic [`LRB_PORT_W-1:0]  out_a_q;
    logic [`LRB_PORT_W-1:0]  out_b_q;
    logic [`LRB_ROW_W-1:0]   rdata_a;
    logic [`LRB_ROW_W-1:0]   rdata_b;

    // Configuration decode
    wire [2:0] k_a      = 3'(geom_a_i);
    wire [2:0] k_b      = 3'(geom_b_i);
    wire       a144     = geom_a_i == LRB_W144;
    wire       b144     = geom_b_i == LRB_W144;
    wire       bad_code = (k_a > 3'h4) || (k_b > 3'h4);
    wire       sdp      = (mode_i == LRB_SDP) || (mode_i == LRB_FIFO);
    wire       tdp      = mode_i == LRB_TDP;
    wire       sp       = mode_i == LRB_SP;
    wire       sdp144   = sdp && a144 && b144;
    wire       cfg_err_d = bad_code
                         || (tdp && (a144 || b144))
                         || (sdp && (a144 ^ b144))
                         || (sp && a144);

    // Role of each port per mode
    wire wr_a = act_a_q && req_a_q.we && !cfg_err_q;
    wire wr_b = act_b_q && req_b_q.we && !cfg_err_q && tdp;
    wire rd_a = act_a_q && !req_a_q.we && !cfg_err_q && (tdp || sp);
    wire rd_b = act_b_q && !cfg_err_q
             && (sdp || (tdp && !req_b_q.we));

    // Write lanes and row data
    wire [15:0]  mask16_a = {req_b_q.mask, req_a_q.mask};
    wire [15:0]  mask16_b = {8'h0, req_b_q.mask};
    wire [71:0]  lanes_a  = widen(req_a_q.din, parity_a_i);
    wire [71:0]  lanes_b  = widen(req_b_q.din, parity_b_i);
    wire [143:0] wdata_a  = place({lanes_b, lanes_a}, k_a);
    wire [143:0] wdata_b  = place({lanes_b, lanes_b}, k_b);
    wire [15:0]  lane_we_a = wr_a ?
        lane_sel(k_a, req_a_q.addr[3:0], mask16_a) : 16'h0;
    wire [15:0]  lane_we_b = wr_b ?
        lane_sel(k_b, req_b_q.addr[3:0], mask16_b) : 16'h0;
    wire [11:0]  row_a = row_of(k_a, req_a_q.addr);
    wire [11:0]  row_b = row_of(k_b, req_b_q.addr);

    // Read data back to port width
    wire [3:0]  st_b  = sdp144 ? 4'h8 : rofs_b_q;
    wire [71:0] raw_a = sdp144 ?
        narrow(pick(rdata_b, 4'h0, k_b), parity_b_i) :
        narrow(pick(rdata_a, rofs_a_q, k_a), parity_a_i);
    wire [71:0] raw_b = narrow(pick(rdata_b, st_b, k_b), parity_b_i);

    lrb_mem u_mem (
        .clk_i     (clk_i),
        .srst_i    (srst_i),
        .a_row_i   (row_a),
        .a_we_i    (lane_we_a),
        .a_wdata_i (wdata_a),
        .a_rd_i    (rd_a),
        .a_rdata_o (rdata_a),
        .b_row_i   (row_b),
        .b_we_i    (lane_we_b),
        .b_wdata_i (wdata_b),
        .b_rd_i    (rd_b),
        .b_rdata_o (rdata_b)
    );

    // Input registers, loaded together on each port's enable
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            req_a_q <= '0;
            req_b_q <= '0;
            act_a_q <= 1'b0;
            act_b_q <= 1'b0;
            cfg_err_q <= 1'b0;
        end else begin
            if (ce_a_i) req_a_q <= req_a_i;
            if (ce_b_i) req_b_q <= req_b_i;
            act_a_q <= ce_a_i;
            act_b_q <= ce_b_i;
            cfg_err_q <= cfg_err_d;
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            rofs_a_q <= `LRB_RST_OFS;
            rofs_b_q <= `LRB_RST_OFS;
        end else begin
            if (rd_a) rofs_a_q <= ofs_of(k_a, req_a_q.addr);
            if (rd_b) rofs_b_q <= ofs_of(k_b, req_b_q.addr);
        end
    end

    // Output registers; clear leaves the array alone
    always_ff @(posedge clk_i) begin
        if (srst_i || clr_a_i) out_a_q <= `LRB_RST_DOUT;
        else if (oce_a_i) out_a_q <= raw_a;
    end

    always_ff @(posedge clk_i) begin
        if (srst_i || clr_b_i) out_b_q <= `LRB_RST_DOUT;
        else if (oce_b_i) out_b_q <= raw_b;
    end

    assign dout_a_o = clr_a_i ? `LRB_RST_DOUT :
                      (obypass_a_i ? raw_a : out_a_q);
    assign dout_b_o = clr_b_i ? `LRB_RST_DOUT :
                      (obypass_b_i ? raw_b : out_b_q);
    assign cfg_err_o = cfg_err_q;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);

    tdp_wide_a: assert property (tdp && (a144 || b144) |=> cfg_err_o)
        else $error("144-bit geometry accepted in true dual-port");

    sdp_pair_a: assert property (sdp && (a144 ^ b144) |=> cfg_err_o)
        else $error("144-bit paired with narrower geometry");

    tdp_legal_a: assert property (tdp && !a144 && !b144 && !bad_code
                                  |=> !cfg_err_o)
        else $error("legal true dual-port geometry refused");

    clr_zero_a: assert property (clr_a_i |-> dout_a_o == `LRB_RST_DOUT
                                  ##1 out_a_q == `LRB_RST_DOUT)
        else $error("port A clear did not zero the output");

    rw_excl_a: assert property (!(rd_a && wr_a) && !(rd_b && wr_b))
        else $error("port reads and writes in one cycle");

    no_write_a: assert property (!wr_a |-> lane_we_a == 16'h0)
        else $error("lanes written without write enable");

    mask72_a: assert property (wr_a && geom_a_i == LRB_W72
                               && !req_a_q.addr[0]
                               |-> lane_we_a == {8'h0, req_a_q.mask})
        else $error("x72 lane mask mismatch");

    mask144_a: assert property (wr_a && sdp144
                                |-> lane_we_a == mask16_a)
        else $error("joined 16-lane mask mismatch");

    in_reg_a: assert property (ce_a_i |=> act_a_q
                               && req_a_q == $past(req_a_i))
        else $error("port A inputs not captured");

    out_reg_a: assert property (oce_b_i && !clr_b_i
                                |=> out_b_q == $past(raw_b))
        else $error("port B output register did not load");
endmodule

//--- lrb_ram_tb_top.sv
// Purpose: Self-checking bench of the large dual-port RAM block
// Assumes: Lanes 0..127 are written before any read of them
// Notes:   Expected reads queue up; a monitor compares them when due
`timescale 1ns/10ps
`define CHK(g, e) begin \
    n_compared++; \
    if ((g) !== (e)) begin \
        n_fail++; \
        $display("[ERR] t=%0t got %h exp %h", $time, (g), (e)); \
    end \
end

module lrb_ram_tb_top
    import lrb_pkg::*;
;
    typedef struct {
        int           due;
        logic [1:0]   sel;
        logic [143:0] v;
        logic [143:0] care;
    } lrb_exp_s;

    logic         clk;
    logic         srst;
    lrb_mode_e    md;
    lrb_geom_e    ga;
    lrb_geom_e    gb;
    logic         par;
    logic         ob;
    logic         oce;
    logic         cfg_err;
    lrb_req_s     req_a;
    lrb_req_s     req_b;
    logic         ce_a;
    logic         ce_b;
    logic         clr_a;
    logic         clr_b;
    logic [71:0]  dout_a;
    logic [71:0]  dout_b;
    int           seed = 3078;
    int           cyc = 0;
    int           n_fail = 0;
    int           n_compared = 0;
    logic [31:0]  rk;
    logic [8:0]   mem_m [int];
    lrb_exp_s     exp_q [$];
    lrb_exp_s     e;
    logic [143:0] g;
    lrb_mode_e    bad_m [6] = '{LRB_TDP, LRB_SP, LRB_SDP, LRB_SDP, LRB_TDP,
                                LRB_SDP};
    logic [2:0]   bad_a [6] = '{3'h4, 3'h4, 3'h4, 3'h3, 3'h5, 3'h2};
    logic [2:0]   bad_b [6] = '{3'h4, 3'h0, 3'h3, 3'h4, 3'h0, 3'h7};

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk) cyc <= cyc + 1;

    lrb_fab i_fab_a (.clk_i(clk), .req_o(req_a), .ce_o(ce_a), .clr_o(clr_a));
    lrb_fab i_fab_b (.clk_i(clk), .req_o(req_b), .ce_o(ce_b), .clr_o(clr_b));

    lrb_ram i_dut (
        .clk_i       (clk),
        .srst_i      (srst),
        .mode_i      (md),
        .geom_a_i    (ga),
        .geom_b_i    (gb),
        .parity_a_i  (par),
        .parity_b_i  (par),
        .obypass_a_i (ob),
        .obypass_b_i (ob),
        .cfg_err_o   (cfg_err),
        .req_a_i     (req_a),
        .ce_a_i      (ce_a),
        .oce_a_i     (oce),
        .clr_a_i     (clr_a),
        .dout_a_o    (dout_a),
        .req_b_i     (req_b),
        .ce_b_i      (ce_b),
        .oce_b_i     (oce),
        .clr_b_i     (clr_b),
        .dout_b_o    (dout_b)
    );

    function automatic logic [143:0] care_f(int n);
        return (144'h1 << (n * (par ? 9 : 8))) - 144'h1;
    endfunction

    function automatic logic [143:0] rd_m(int n, int a);
        logic [143:0] v;
        v = '0;
        for (int i = 0; i < n; i++) begin
            if (par) v[9*i+:9] = mem_m[a*n+i];
            else v[8*i+:8] = mem_m[a*n+i][7:0];
        end
        return v;
    endfunction

    function automatic void wr_m(int n, int a, logic [143:0] d,
                                 logic [15:0] m);
        for (int i = 0; i < n; i++)
            if (n == 1 || m[i])
                mem_m[a*n+i] = par ? d[9*i+:9] : {1'b0, d[8*i+:8]};
    endfunction

    // One cycle on both ports: fill write (fa >= 0), idle or random
    task automatic cyc_op(input int fa, input logic quiet);
        lrb_req_s     qa;
        lrb_req_s     qb;
        logic [159:0] r;
        logic [31:0]  s;
        logic         ca;
        logic         cb;
        logic         ra;
        logic         rb;
        logic         wide;
        logic [143:0] va;
        logic [143:0] vb;
        int           na;
        int           nb;
        na = 1 << ga;
        nb = 1 << gb;
        wide = (ga == LRB_W144);
        r = {$random(seed), $random(seed), $random(seed), $random(seed),
             $random(seed)};
        s = $random(seed);
        qa = r[96:0];
        qb = r[159:63];
        qa.addr = 16'(int'(qa.addr) % (128 / na));
        qb.addr = 16'(int'(qb.addr) % (128 / nb));
        ca = (s[2:0] != 3'h0) && !quiet;
        cb = (s[5:3] != 3'h0) && !quiet && (md != LRB_SP);
        if (md != LRB_TDP && md != LRB_SP) qa.we = 1'b1;
        if (fa >= 0) begin
            ca = 1'b1;
            cb = wide;
            qa.we = 1'b1;
            qa.addr = 16'(fa);
            qa.mask = 8'hff;
            qb.mask = 8'hff;
        end
        if (wide && ca) cb = 1'b1;
        ra = ca && !qa.we;
        rb = cb && !(wide && ca) && (md != LRB_TDP || !qb.we);
        va = ra ? rd_m(na, qa.addr) : '0;
        vb = rb ? rd_m(nb, qb.addr) : '0;
        if (ca && qa.we)
            wr_m(na, qa.addr, !wide ? {72'h0, qa.din} : par ?
                 {qb.din, qa.din} : {16'h0, qb.din[63:0], qa.din[63:0]},
                 {qb.mask, qa.mask});
        if (cb && qb.we && md == LRB_TDP)
            wr_m(nb, qb.addr, {72'h0, qb.din}, {8'h0, qb.mask});
        fork
            i_fab_a.acc(qa, ca);
            i_fab_b.acc(qb, cb);
        join
        if (ra) exp_q.push_back('{cyc + (ob ? 2 : 3), 2'h0, va, care_f(na)});
        if (rb && wide && !par)
            vb = {8'h0, vb[127:64], 8'h0, vb[63:0]};
        if (rb)
            exp_q.push_back('{cyc + (ob ? 2 : 3), wide ? 2'h2 : 2'h1, vb,
                              (wide && !par) ? {2{8'h0, {64{1'b1}}}}
                                             : care_f(nb)});
    endtask

    task automatic cfg(input lrb_mode_e m, input logic [2:0] a,
                       input logic [2:0] b, input logic p, input logic o,
                       input logic err);
        repeat (4) cyc_op(-1, 1'b1);
        md = m;
        ga = lrb_geom_e'(a);
        gb = lrb_geom_e'(b);
        par = p;
        ob = o;
        mem_m.delete();
        repeat (2) cyc_op(-1, 1'b1);
        exp_q.push_back('{cyc, 2'h3, {143'h0, err}, 144'h1});
    endtask

    task automatic clr_both();
        repeat (3) cyc_op(-1, 1'b1);
        fork
            i_fab_a.clr(1'b1);
            i_fab_b.clr(1'b1);
        join
        oce = 1'b0;
        exp_q.push_back('{cyc, 2'h2, 144'h0, '1});
        fork
            i_fab_a.clr(1'b0);
            i_fab_b.clr(1'b0);
        join
        // Output register must hold zero while its enable is low
        if (!ob) exp_q.push_back('{cyc + 1, 2'h2, 144'h0, '1});
        cyc_op(-1, 1'b1);
        oce = 1'b1;
    endtask

    task automatic close_out();
        if (exp_q.size() != 0) n_fail++;
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Compares each noted result in the cycle it falls due
    always @(posedge clk) begin
        #4;
        while (exp_q.size() > 0 && exp_q[0].due == cyc) begin
            e = exp_q.pop_front();
            g = e.sel == 2'h3 ? {143'h0, cfg_err} :
                e.sel == 2'h2 ? {dout_b, dout_a} :
                {72'h0, e.sel[0] ? dout_b : dout_a};
            `CHK(g & e.care, e.v & e.care)
        end
    end

    initial begin
        repeat (60000) @(posedge clk);
        n_fail++;
        close_out();
    end

    initial begin
        srst = 1'b1;
        md = LRB_TDP;
        ga = LRB_W72;
        gb = LRB_W72;
        par = 1'b1;
        ob = 1'b1;
        oce = 1'b1;
        repeat (4) @(posedge clk);
        #2;
        srst = 1'b0;
        exp_q.push_back('{cyc + 1, 2'h2, 144'h0, '1});
        exp_q.push_back('{cyc + 1, 2'h3, 144'h0, 144'h1});
        for (int k = 0; k < 12; k++) begin
            rk = $random(seed);
            if (k == 11)
                cfg(LRB_SDP, 3'h4, 3'h4, rk[8], rk[9], 1'b0);
            else
                cfg(lrb_mode_e'(rk[1:0]), {1'b0, rk[3:2]}, {1'b0, rk[5:4]},
                    rk[8], rk[9], 1'b0);
            for (int a = 0; a < 128 / (1 << ga); a++) cyc_op(a, 1'b0);
            repeat (30) cyc_op(-1, 1'b0);
            clr_both();
            repeat (30) cyc_op(-1, 1'b0);
        end
        for (int i = 0; i < 6; i++)
            cfg(bad_m[i], bad_a[i], bad_b[i], 1'b1, 1'b1, 1'b1);
        repeat (4) cyc_op(-1, 1'b1);
        close_out();
    end
endmodule
